/* logic/fdi_regs.svh */
`ifndef FDI_REGS_SVH
`define FDI_REGS_SVH

// Clock period of sys_clk_in.
`define FDI_CLK_PERIOD_NS 5
`define FDI_MS_CYCLES (1000000 / `FDI_CLK_PERIOD_NS)

// Power-on reset pulse, a least time.
`define FDI_POR_TIME_NS 10000
`define FDI_POR_CYCLES ((`FDI_POR_TIME_NS + `FDI_CLK_PERIOD_NS - 1) / `FDI_CLK_PERIOD_NS)

// Index/sector output pulse width, a least time.
`define FDI_INDEX_PULSE_NS 1000
`define FDI_INDEX_CYCLES ((`FDI_INDEX_PULSE_NS + `FDI_CLK_PERIOD_NS - 1) / `FDI_CLK_PERIOD_NS)

// Write bit cell period.
`define FDI_BIT_CELL_NS 4000
`define FDI_BIT_CELL_CYCLES (`FDI_BIT_CELL_NS / `FDI_CLK_PERIOD_NS)

// Positioning and spin-up times in milliseconds.
`define FDI_SPINUP_MS 1000
`define FDI_STEP_MS 25
`define FDI_SETTLE_MS 15
`define FDI_HEAD_LOAD_MS 50

`define FDI_TIMER_W 12
`define FDI_LONG_W 28
`define FDI_BYTE_W 8
`define FDI_FIFO_DEPTH 8

// Bit positions in the synchronised pin vector.
`define FDI_SI_SELECT 0
`define FDI_SI_MOTOR 1
`define FDI_SI_HEAD_LOAD 2
`define FDI_SI_STEP 3
`define FDI_SI_DIR 4
`define FDI_SI_WGATE 5
`define FDI_SI_INDEX 6
`define FDI_SI_TRK0 7
`define FDI_SI_NOTCH 8
`define FDI_SI_SUPPLY_LOW 9
`define FDI_SI_READ_DATA 10
`define FDI_SI_OPT_HS 11
`define FDI_SI_OPT_HM 12
`define FDI_SI_OPT_WP_IF 13
`define FDI_SI_W 14

`endif

/* logic/fdi_pkg.sv */
package fdi_pkg;

  // Stepper phase energisation, one winding at a time.
  typedef enum logic [3:0] {
    FDI_PH_A = 4'h1,
    FDI_PH_B = 4'h2,
    FDI_PH_C = 4'h4,
    FDI_PH_D = 4'h8
  } fdi_phase_t;

endpackage

/* logic/fdi_sync.sv */
`timescale 1ns/1ps
module fdi_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fdi_sync_state_t;

  fdi_sync_state_t s;
  fdi_sync_state_t next_s;

  always_comb begin
    next_s.s1 = async_in;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.s2;

endmodule // fdi_sync

/* logic/fdi_fifo.sv */
`timescale 1ns/1ps
module fdi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fdi_fifo_state_t;

  fdi_fifo_state_t s;
  fdi_fifo_state_t next_s;
  logic            push;
  logic            pop;

  assign in_ready_out  = (s.cnt != FULL);
  assign out_valid_out = (s.cnt != '0);
  assign out_data_out  = s.mem[s.rd];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data_in;
      next_s.wr = (s.wr == LAST) ? '0 : s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = (s.rd == LAST) ? '0 : s.rd + 1'b1;
    end
    case ({push, pop})
      2'b10: next_s.cnt = s.cnt + 1'b1;
      2'b01: next_s.cnt = s.cnt - 1'b1;
      default: next_s.cnt = s.cnt;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule // fdi_fifo

/* logic/fdi_ctl.sv */
// Summary of operation
// - Unselected drive ignores interface inputs other than motor-on.
// - Select gates head-load line, enables inputs, outputs.
// - Power-on reset clears logic, inhibits writing.
// - Without head-load line, select/motor loads head.
// - Each step pulse moves one track.
// - Steps become ordered stepper phase sequence.
// - No stepping while writing.
// - One output pulse per index/sector hole.
// - Track-zero output follows track-zero switch.
// - Covered notch flags protect, blocks writing unless protect-status-only is set.
// - Write only with write gate on selected.
// - Erase current accompanies writing.
// - Write gate low selects read mode.
// - Low supply disables write and erase.
// - Motor-on input drives spindle independently.
// - Hard sectors give index and sector pulses.
// - Soft sectors give index pulse only.
// - Head-on-motor option loads head from motor.
// - Select lights lamp, head-on-select loads head.
`timescale 1ns/1ps
`include "fdi_regs.svh"
module fdi_ctl #(
  parameter int unsigned SPINUP_CYCLES    = `FDI_SPINUP_MS * `FDI_MS_CYCLES,
  parameter int unsigned STEP_CYCLES      = `FDI_STEP_MS * `FDI_MS_CYCLES,
  parameter int unsigned SETTLE_CYCLES    = `FDI_SETTLE_MS * `FDI_MS_CYCLES,
  parameter int unsigned HEAD_LOAD_CYCLES = `FDI_HEAD_LOAD_MS * `FDI_MS_CYCLES,
  parameter int          FIFO_WIDTH       = `FDI_BYTE_W,
  parameter int          FIFO_DEPTH       = `FDI_FIFO_DEPTH
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  drive_select_in,
  input  wire logic                  motor_on_in,
  input  wire logic                  head_load_in,
  input  wire logic                  step_in,
  input  wire logic                  direction_in,
  input  wire logic                  write_gate_in,
  input  wire logic                  index_sensor_in,
  input  wire logic                  track_zero_switch_in,
  input  wire logic                  notch_covered_in,
  input  wire logic                  supply_low_in,
  input  wire logic                  read_data_in,
  input  wire logic                  head_on_select_option_in,
  input  wire logic                  head_on_motor_option_in,
  input  wire logic                  protect_status_only_in,
  input  wire logic                  write_data_valid_in,
  input  wire logic [FIFO_WIDTH-1:0] write_data_in,
  output logic                       write_data_ready_out,
  output logic                       select_lamp_out,
  output logic                       head_load_out,
  output logic                       spindle_motor_out,
  output logic      [3:0]            stepper_phase_out,
  output logic                       index_sector_out,
  output logic                       track_zero_out,
  output logic                       write_protect_out,
  output logic                       write_enable_out,
  output logic                       erase_enable_out,
  output logic                       write_bit_out,
  output logic                       read_mode_out,
  output logic                       read_data_out,
  output logic                       power_on_reset_out,
  output logic                       step_too_fast_out,
  output logic                       drive_ready_out
);

  localparam logic [`FDI_TIMER_W-1:0] POR_CNT   = `FDI_TIMER_W'(`FDI_POR_CYCLES);
  localparam logic [`FDI_TIMER_W-1:0] INDEX_CNT = `FDI_TIMER_W'(`FDI_INDEX_CYCLES);
  localparam logic [`FDI_TIMER_W-1:0] CELL_CNT  = `FDI_TIMER_W'(`FDI_BIT_CELL_CYCLES - 1);
  localparam logic [`FDI_LONG_W-1:0]  SPIN_LIM  = `FDI_LONG_W'(SPINUP_CYCLES);
  localparam logic [`FDI_LONG_W-1:0]  STEP_LIM  = `FDI_LONG_W'(STEP_CYCLES);
  localparam logic [`FDI_LONG_W-1:0]  SETL_LIM  = `FDI_LONG_W'(SETTLE_CYCLES);
  localparam logic [`FDI_LONG_W-1:0]  LOAD_LIM  = `FDI_LONG_W'(HEAD_LOAD_CYCLES);
  localparam logic [3:0]              BYTE_BITS = 4'(FIFO_WIDTH);

  typedef struct packed {
    logic                     por_done;
    logic [`FDI_TIMER_W-1:0]  por_cnt;
    logic                     step_prev;
    logic                     idx_prev;
    logic [`FDI_TIMER_W-1:0]  idx_cnt;
    logic [`FDI_TIMER_W-1:0]  cell_cnt;
    logic [3:0]               bits_left;
    logic [FIFO_WIDTH-1:0]    shreg;
    logic [`FDI_LONG_W-1:0]   spin_cnt;
    logic [`FDI_LONG_W-1:0]   load_cnt;
    logic [`FDI_LONG_W-1:0]   settle_cnt;
    logic [`FDI_LONG_W-1:0]   gap_cnt;
    fdi_pkg::fdi_phase_t      phase;
    logic                     lamp;
    logic                     head_load;
    logic                     spindle;
    logic                     index_out;
    logic                     trk0_out;
    logic                     wp_out;
    logic                     wr_en;
    logic                     erase_en;
    logic                     wr_bit;
    logic                     read_mode;
    logic                     read_bit;
    logic                     too_fast;
    logic                     ready;
  } fdi_ctl_state_t;

  fdi_ctl_state_t          s;
  fdi_ctl_state_t          next_s;
  logic [`FDI_SI_W-1:0]    pins;
  logic [`FDI_SI_W-1:0]    sy;
  logic                    sel;
  logic                    wgate;
  logic                    inhibit;
  logic                    write_ok;
  logic                    step_edge;
  logic                    do_step;
  logic                    idx_edge;
  logic                    load_want;
  logic                    cell_tick;
  logic                    fifo_valid;
  logic                    fifo_ready;
  logic [FIFO_WIDTH-1:0]   fifo_data;

  // Saturating up-counter used by the positioning and spin-up timers.
  function automatic logic [`FDI_LONG_W-1:0] sat_inc(
    input logic [`FDI_LONG_W-1:0] cnt,
    input logic [`FDI_LONG_W-1:0] lim
  );
    sat_inc = (cnt >= lim) ? cnt : cnt + 1'b1;
  endfunction

  always_comb begin
    pins                          = '0;
    pins[`FDI_SI_SELECT]          = drive_select_in;
    pins[`FDI_SI_MOTOR]           = motor_on_in;
    pins[`FDI_SI_HEAD_LOAD]       = head_load_in;
    pins[`FDI_SI_STEP]            = step_in;
    pins[`FDI_SI_DIR]             = direction_in;
    pins[`FDI_SI_WGATE]           = write_gate_in;
    pins[`FDI_SI_INDEX]           = index_sensor_in;
    pins[`FDI_SI_TRK0]            = track_zero_switch_in;
    pins[`FDI_SI_NOTCH]           = notch_covered_in;
    pins[`FDI_SI_SUPPLY_LOW]      = supply_low_in;
    pins[`FDI_SI_READ_DATA]       = read_data_in;
    pins[`FDI_SI_OPT_HS]          = head_on_select_option_in;
    pins[`FDI_SI_OPT_HM]          = head_on_motor_option_in;
    pins[`FDI_SI_OPT_WP_IF]       = protect_status_only_in;
  end

  fdi_sync #(
    .W (`FDI_SI_W)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (pins),
    .sync_out   (sy)
  );

  // Write data is buffered so the controller can run ahead of the bit cells.
  fdi_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (write_data_valid_in),
    .in_ready_out  (write_data_ready_out),
    .in_data_in    (write_data_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_ready),
    .out_data_out  (fifo_data)
  );

  assign sel = sy[`FDI_SI_SELECT];
  assign wgate = sel & sy[`FDI_SI_WGATE];
  assign inhibit = sy[`FDI_SI_NOTCH] & ~sy[`FDI_SI_OPT_WP_IF];
  assign write_ok = wgate & s.por_done & ~sy[`FDI_SI_SUPPLY_LOW] & ~inhibit;

  assign step_edge = sy[`FDI_SI_STEP] & ~s.step_prev;
  assign do_step = step_edge & sel & ~wgate & s.por_done;

  assign idx_edge  = sy[`FDI_SI_INDEX] & ~s.idx_prev;
  assign cell_tick = write_ok & (s.cell_cnt == CELL_CNT);
  assign fifo_ready = cell_tick & (s.bits_left == 4'h0);

  always_comb begin
    if (sy[`FDI_SI_OPT_HS]) begin
      load_want = sel;
    end else if (sy[`FDI_SI_OPT_HM]) begin
      load_want = sy[`FDI_SI_MOTOR];
    end else begin
      load_want = sel & sy[`FDI_SI_HEAD_LOAD];
    end
  end

  always_comb begin
    next_s = s;
    next_s.step_prev = sy[`FDI_SI_STEP];
    next_s.idx_prev  = sy[`FDI_SI_INDEX];

    if (!s.por_done) begin
      next_s.por_cnt = s.por_cnt + 1'b1;
      if (s.por_cnt == POR_CNT - 1'b1) begin
        next_s.por_done = 1'b1;
      end
    end

    if (do_step) begin
      case (s.phase)
        fdi_pkg::FDI_PH_A: next_s.phase = sy[`FDI_SI_DIR] ? fdi_pkg::FDI_PH_B : fdi_pkg::FDI_PH_D;
        fdi_pkg::FDI_PH_B: next_s.phase = sy[`FDI_SI_DIR] ? fdi_pkg::FDI_PH_C : fdi_pkg::FDI_PH_A;
        fdi_pkg::FDI_PH_C: next_s.phase = sy[`FDI_SI_DIR] ? fdi_pkg::FDI_PH_D : fdi_pkg::FDI_PH_B;
        fdi_pkg::FDI_PH_D: next_s.phase = sy[`FDI_SI_DIR] ? fdi_pkg::FDI_PH_A : fdi_pkg::FDI_PH_C;
        default: next_s.phase = fdi_pkg::FDI_PH_A;
      endcase
    end

    // stretch each hole into a pulse
    if (idx_edge) begin
      next_s.idx_cnt = INDEX_CNT;
    end else if (s.idx_cnt != '0) begin
      next_s.idx_cnt = s.idx_cnt - 1'b1;
    end

    // Step spacing and settle timers restart on every accepted step.
    if (do_step) begin
      // flag steps closer than single-track time
      next_s.too_fast   = s.too_fast | (s.gap_cnt < STEP_LIM);
      next_s.gap_cnt    = '0;
      next_s.settle_cnt = '0;
    end else begin
      next_s.gap_cnt    = sat_inc(s.gap_cnt, STEP_LIM);
      next_s.settle_cnt = sat_inc(s.settle_cnt, SETL_LIM);
    end
    if (!sel) begin
      next_s.too_fast = 1'b0;
    end

    next_s.spin_cnt = sy[`FDI_SI_MOTOR] ? sat_inc(s.spin_cnt, SPIN_LIM) : '0;
    next_s.load_cnt = load_want ? sat_inc(s.load_cnt, LOAD_LIM) : '0;

    // Write serialiser, most significant bit first, one bit per cell.
    if (!write_ok) begin
      next_s.cell_cnt  = '0;
      next_s.bits_left = 4'h0;
      next_s.wr_bit    = 1'b0;
    end else begin
      next_s.cell_cnt = cell_tick ? '0 : s.cell_cnt + 1'b1;
      if (cell_tick) begin
        if (s.bits_left != 4'h0) begin
          next_s.wr_bit    = s.shreg[FIFO_WIDTH-1];
          next_s.shreg     = s.shreg << 1;
          next_s.bits_left = s.bits_left - 1'b1;
        end else if (fifo_valid) begin
          next_s.wr_bit    = fifo_data[FIFO_WIDTH-1];
          next_s.shreg     = fifo_data << 1;
          next_s.bits_left = BYTE_BITS - 1'b1;
        end else begin
          next_s.wr_bit = 1'b0;
        end
      end
    end

    next_s.lamp      = sel;
    next_s.head_load = load_want;
    next_s.spindle   = sy[`FDI_SI_MOTOR];
    next_s.index_out = sel & ((s.idx_cnt != '0) | idx_edge);
    next_s.trk0_out  = sel & sy[`FDI_SI_TRK0];
    next_s.wp_out    = sel & sy[`FDI_SI_NOTCH];
    next_s.wr_en     = write_ok;
    next_s.erase_en  = write_ok;
    next_s.read_mode = sel & ~sy[`FDI_SI_WGATE];
    next_s.read_bit  = sel & ~sy[`FDI_SI_WGATE] & sy[`FDI_SI_READ_DATA];
    next_s.ready     = sel & s.por_done & (s.spin_cnt >= SPIN_LIM) & (s.load_cnt >= LOAD_LIM)
                       & (s.settle_cnt >= SETL_LIM);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      s       <= '0;
      s.phase <= fdi_pkg::FDI_PH_A;
    end else begin
      s <= next_s;
    end
  end

  assign select_lamp_out    = s.lamp;
  assign head_load_out      = s.head_load;
  assign spindle_motor_out  = s.spindle;
  assign stepper_phase_out  = s.phase;
  assign index_sector_out   = s.index_out;
  assign track_zero_out     = s.trk0_out;
  assign write_protect_out  = s.wp_out;
  assign write_enable_out   = s.wr_en;
  assign erase_enable_out   = s.erase_en;
  assign write_bit_out      = s.wr_bit;
  assign read_mode_out      = s.read_mode;
  assign read_data_out      = s.read_bit;
  assign power_on_reset_out = ~s.por_done;
  assign step_too_fast_out  = s.too_fast;
  assign drive_ready_out    = s.ready;

endmodule // fdi_ctl

/* tb/fdi_checker.sv */
`timescale 1ns/1ps
`include "fdi_regs.svh"
module fdi_checker (
  input wire logic       sys_clk_in,
  input wire logic       reset_n_in,
  input wire logic       drive_select_in,
  input wire logic       motor_on_in,
  input wire logic       step_in,
  input wire logic       direction_in,
  input wire logic       write_gate_in,
  input wire logic       track_zero_switch_in,
  input wire logic       notch_covered_in,
  input wire logic       supply_low_in,
  input wire logic       protect_status_only_in,
  input wire logic       select_lamp_out,
  input wire logic       spindle_motor_out,
  input wire logic [3:0] stepper_phase_out,
  input wire logic       track_zero_out,
  input wire logic       write_protect_out,
  input wire logic       write_enable_out,
  input wire logic       erase_enable_out,
  input wire logic       read_mode_out,
  input wire logic       power_on_reset_out
);
  logic [2:0] up;
  logic [3:0] ph_q;
  logic       live;
  logic [11:0] por_n;
  // Pin history is only trusted once the sync stages hold post-reset samples.
  always_ff @(posedge sys_clk_in) up <= !reset_n_in ? 3'h0 : (up == 3'h7 ? up : up + 3'h1);
  // Counts edges since reset release, saturating, to time the power-on pulse.
  always_ff @(posedge sys_clk_in) por_n <= !reset_n_in ? 12'h000 : (por_n == 12'hFFF ? por_n : por_n + 12'h001);
  always_ff @(posedge sys_clk_in) ph_q <= stepper_phase_out;
  assign live = up >= 3'h5;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence s_por_hold;
    power_on_reset_out [*8];
  endsequence
  property p_por;
    $rose(reset_n_in) |-> s_por_hold;
  endproperty
  property p_por_len;
    power_on_reset_out == (por_n < `FDI_POR_CYCLES);
  endproperty
  property p_lamp;
    live |-> select_lamp_out == $past(drive_select_in, 3);
  endproperty
  property p_spin;
    live |-> spindle_motor_out == $past(motor_on_in, 3);
  endproperty
  property p_tz;
    live |-> track_zero_out == $past(drive_select_in && track_zero_switch_in, 3);
  endproperty
  property p_wp;
    live |-> write_protect_out == $past(drive_select_in && notch_covered_in, 3);
  endproperty
  property p_write;
    live && write_enable_out |-> $past(drive_select_in && write_gate_in && !supply_low_in, 3) && !power_on_reset_out
      && ($past(protect_status_only_in, 3) || !$past(notch_covered_in, 3));
  endproperty
  property p_erase;
    erase_enable_out == write_enable_out;
  endproperty
  property p_read;
    live |-> read_mode_out == $past(drive_select_in && !write_gate_in, 3);
  endproperty
  property p_step;
    live && stepper_phase_out != ph_q |-> $past(step_in, 3) && !$past(step_in, 4) && $past(drive_select_in, 3)
      && !$past(write_gate_in, 3)
      && stepper_phase_out == ($past(direction_in, 3) ? {ph_q[2:0], ph_q[3]} : {ph_q[0], ph_q[3:1]});
  endproperty
  a_por: assert property (p_por) else $error("power-on reset not held after release");
  a_por_len: assert property (p_por_len) else $error("power-on reset length wrong");
  a_lamp: assert property (p_lamp) else $error("lamp does not follow select");
  a_spin: assert property (p_spin) else $error("spindle does not follow motor");
  a_tz: assert property (p_tz) else $error("track zero status wrong");
  a_wp: assert property (p_wp) else $error("protect status wrong");
  a_write: assert property (p_write) else $error("write enabled without cause");
  a_erase: assert property (p_erase) else $error("erase differs from write");
  a_read: assert property (p_read) else $error("read mode wrong");
  a_step: assert property (p_step) else $error("phase move without valid step");
endmodule // fdi_checker

bind fdi_ctl fdi_checker u_chk (.sys_clk_in, .reset_n_in, .drive_select_in, .motor_on_in, .step_in, .direction_in,
  .write_gate_in, .track_zero_switch_in, .notch_covered_in, .supply_low_in, .protect_status_only_in,
  .select_lamp_out, .spindle_motor_out, .stepper_phase_out, .track_zero_out, .write_protect_out,
  .write_enable_out, .erase_enable_out, .read_mode_out, .power_on_reset_out);

/* tb/fdi_host_model.sv */
`timescale 1ns/1ps
module fdi_host_model #(
  parameter int GAP    = 30,
  parameter int SETTLE = 10
) (
  input  wire logic       sys_clk_in,
  input  wire logic       seek_go_in,
  input  wire logic       home_in,
  input  wire logic       dir_in,
  input  wire logic [7:0] count_in,
  input  wire logic       track_zero_in,
  output logic            step_out,
  output logic            direction_out,
  output logic            busy_out
);
  initial begin
    int n;
    step_out = 1'b0;
    direction_out = 1'b0;
    busy_out = 1'b0;
    forever begin
      @(posedge sys_clk_in);
      if (seek_go_in) begin
        busy_out <= 1'b1;
        direction_out <= home_in ? 1'b0 : dir_in;
        n = 0;
        while (home_in ? (track_zero_in !== 1'b1 && n < 99) : n < count_in) begin
          n++;
          @(posedge sys_clk_in);
          step_out <= 1'b1;
          repeat (4) @(posedge sys_clk_in);
          step_out <= 1'b0;
          repeat (GAP - 4) @(posedge sys_clk_in);
        end
        repeat (SETTLE) @(posedge sys_clk_in);
        busy_out <= 1'b0;
      end
    end
  end
endmodule // fdi_host_model

/* tb/fdi_ctl_tb.sv */
`timescale 1ns/1ps
module fdi_ctl_tb;
  logic sys_clk_in = 1'b0, reset_n_in = 1'b0, drive_select_in = 1'b0, motor_on_in = 1'b0, head_load_in = 1'b0;
  logic write_gate_in = 1'b0, index_sensor_in = 1'b0, notch_covered_in = 1'b0, supply_low_in = 1'b0;
  logic read_data_in = 1'b0, head_on_select_option_in = 1'b0, head_on_motor_option_in = 1'b0;
  logic protect_status_only_in = 1'b0, write_data_valid_in = 1'b0, seek_go = 1'b0, seek_home = 1'b0, seek_dir = 1'b0;
  logic [7:0] write_data_in = 8'h00, seek_n = 8'h00;
  logic step_in, direction_in, busy, track_zero_switch_in, write_data_ready_out, select_lamp_out, head_load_out;
  logic spindle_motor_out, index_sector_out, track_zero_out, write_protect_out, write_enable_out, erase_enable_out;
  logic write_bit_out, read_mode_out, read_data_out, power_on_reset_out, step_too_fast_out, drive_ready_out;
  logic [3:0] stepper_phase_out, ph_q = 4'h1;
  int   trk = 3, checks = 0, failures = 0;

  initial forever #2.5 sys_clk_in = ~sys_clk_in;

  fdi_ctl #(.SPINUP_CYCLES(50), .STEP_CYCLES(20), .SETTLE_CYCLES(10), .HEAD_LOAD_CYCLES(30)) u_dut (
    .sys_clk_in, .reset_n_in, .drive_select_in, .motor_on_in, .head_load_in, .step_in, .direction_in,
    .write_gate_in, .index_sensor_in, .track_zero_switch_in, .notch_covered_in, .supply_low_in, .read_data_in,
    .head_on_select_option_in, .head_on_motor_option_in, .protect_status_only_in, .write_data_valid_in,
    .write_data_in, .write_data_ready_out, .select_lamp_out, .head_load_out, .spindle_motor_out, .stepper_phase_out,
    .index_sector_out, .track_zero_out, .write_protect_out, .write_enable_out, .erase_enable_out, .write_bit_out,
    .read_mode_out, .read_data_out, .power_on_reset_out, .step_too_fast_out, .drive_ready_out);

  fdi_host_model u_host (.sys_clk_in, .seek_go_in(seek_go), .home_in(seek_home),
    .dir_in(seek_dir), .count_in(seek_n), .track_zero_in(track_zero_out), .step_out(step_in),
    .direction_out(direction_in), .busy_out(busy));

  // Head carriage: each phase move shifts one track, the switch closes at track zero.
  always @(posedge sys_clk_in) begin
    ph_q <= stepper_phase_out;
    if (reset_n_in && stepper_phase_out != ph_q) trk <= (stepper_phase_out == {ph_q[2:0], ph_q[3]}) ? trk + 1 : trk - 1;
  end
  assign track_zero_switch_in = (trk == 0);

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic to;
    failures++;
    report_and_stop;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic seek(input logic home, input logic dir, input logic [7:0] n);
    int i;
    seek_home <= home;
    seek_dir <= dir;
    seek_n <= n;
    seek_go <= 1'b1;
    cyc(1);
    seek_go <= 1'b0;
    cyc(2);
    for (i = 0; i < 9000 && busy; i++) cyc(1);
    if (busy) to();
    #1;
  endtask

  task automatic t_por;
    cyc(5);
    drive_select_in <= 1'b1;
    write_gate_in <= 1'b1;
    reset_n_in <= 1'b1;
    #1 chk(stepper_phase_out, 8'h01);
    chk(power_on_reset_out, 8'h01);
    chk(write_data_ready_out, 8'h01);
    cyc(1990);
    #1 chk(power_on_reset_out, 8'h01);
    chk(write_enable_out, 8'h00);
    cyc(20);
    #1 chk(power_on_reset_out, 8'h00);
  endtask

  task automatic t_sel;
    cyc(1);
    write_gate_in <= 1'b0;
    drive_select_in <= 1'b0;
    motor_on_in <= 1'b1;
    head_on_motor_option_in <= 1'b1;
    notch_covered_in <= 1'b1;
    cyc(5);
    #1 chk(spindle_motor_out, 8'h01);
    chk(head_load_out, 8'h01);
    chk(select_lamp_out, 8'h00);
    chk(write_protect_out, 8'h00);
    cyc(1);
    seek(1'b0, 1'b1, 8'h01);
    chk(stepper_phase_out, 8'h01);
    cyc(1);
    head_on_motor_option_in <= 1'b0;
    head_on_select_option_in <= 1'b1;
    cyc(5);
    #1 chk(head_load_out, 8'h00);
    cyc(1);
    drive_select_in <= 1'b1;
    cyc(5);
    #1 chk(head_load_out, 8'h01);
    chk(select_lamp_out, 8'h01);
    chk(write_protect_out, 8'h01);
    cyc(1);
    head_on_select_option_in <= 1'b0;
    notch_covered_in <= 1'b0;
    head_load_in <= 1'b1;
    cyc(5);
    #1 chk(head_load_out, 8'h01);
    cyc(1);
    head_load_in <= 1'b0;
    cyc(5);
    #1 chk(head_load_out, 8'h00);
    cyc(1);
    head_on_select_option_in <= 1'b1;
  endtask

  task automatic t_home;
    seek(1'b1, 1'b0, 8'h00);
    chk(8'(trk == 0), 8'h01);
    chk(track_zero_out, 8'h01);
    chk(stepper_phase_out, 8'h02);
    chk(step_too_fast_out, 8'h00);
    chk(drive_ready_out, 8'h01);
    cyc(1);
    seek(1'b0, 1'b1, 8'h02);
    chk(stepper_phase_out, 8'h08);
    chk(8'(trk), 8'h02);
    chk(track_zero_out, 8'h00);
  endtask

  task automatic t_wr;
    int i;
    cyc(1);
    write_data_valid_in <= 1'b1;
    for (i = 0; i < 8; i++) begin
      write_data_in <= (i == 0) ? 8'hA5 : 8'h3C;
      cyc(1);
    end
    write_data_valid_in <= 1'b0;
    #1 chk(write_data_ready_out, 8'h00);
    chk(write_enable_out, 8'h00);
    chk(drive_ready_out, 8'h01);
    cyc(1);
    write_gate_in <= 1'b1;
    cyc(5);
    #1 chk(write_enable_out, 8'h01);
    chk(erase_enable_out, 8'h01);
    chk(read_mode_out, 8'h00);
    for (i = 0; i < 1000 && write_data_ready_out !== 1'b1; i++) @(negedge sys_clk_in);
    if (write_data_ready_out !== 1'b1) to();
    repeat (400) @(negedge sys_clk_in);
    chk(write_bit_out, 8'h01);
    repeat (800) @(negedge sys_clk_in);
    chk(write_bit_out, 8'h00);
    cyc(1);
    seek(1'b0, 1'b1, 8'h02);
    chk(stepper_phase_out, 8'h08);
    cyc(1);
    notch_covered_in <= 1'b1;
    cyc(5);
    #1 chk(write_protect_out, 8'h01);
    chk(write_enable_out, 8'h00);
    cyc(1);
    protect_status_only_in <= 1'b1;
    cyc(5);
    #1 chk(write_enable_out, 8'h01);
    cyc(1);
    supply_low_in <= 1'b1;
    cyc(5);
    #1 chk(write_enable_out, 8'h00);
    chk(erase_enable_out, 8'h00);
    cyc(1);
    supply_low_in <= 1'b0;
    notch_covered_in <= 1'b0;
    protect_status_only_in <= 1'b0;
    write_gate_in <= 1'b0;
    read_data_in <= 1'b1;
    cyc(5);
    #1 chk(read_mode_out, 8'h01);
    chk(read_data_out, 8'h01);
  endtask

  task automatic t_idx(input logic sel);
    int n, i;
    cyc(1);
    drive_select_in <= sel;
    cyc(5);
    index_sensor_in <= 1'b1;
    n = 0;
    for (i = 0; i < 300; i++) begin
      @(negedge sys_clk_in);
      n += index_sector_out;
    end
    chk(8'(sel ? (n == 200 || n == 201) : (n == 0)), 8'h01);
    cyc(1);
    index_sensor_in <= 1'b0;
    cyc(5);
  endtask

  initial begin
    t_por;
    t_sel;
    t_home;
    t_wr;
    t_idx(1'b1);
    t_idx(1'b1);
    t_idx(1'b0);
    report_and_stop;
  end
endmodule // fdi_ctl_tb
